// file: dv/dual_timer_ctrl_checker.sv
// bus handshake and counter checks for the dual timer block
`timescale 1ns/100ps
`default_nettype none
module dual_timer_ctrl_checker (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // live counts
    input wire logic [7:0]  timer3_count,
    input wire logic [7:0]  timer4_count
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // a full write taken at one edge, and a read address taken
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // answers arrive in time and stand until taken
    chk_write_answer:
        assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer:
        assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
    chk_bvalid_hold:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rvalid_hold:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    chk_rdata_upper:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits set");
    // counters only step by one or clear
    chk_count3_step:
        assert property ($changed(timer3_count) |-> timer3_count == 8'h00
            || (timer3_count - $past(timer3_count)) == 8'h01)
        else $error("timer3 count jumped");
    chk_count4_step:
        assert property ($changed(timer4_count) |-> timer4_count == 8'h00
            || (timer4_count - $past(timer4_count)) == 8'h01)
        else $error("timer4 count jumped");
    chk_reset_clear:
        assert property (disable iff (1'b0) srst
            |=> timer3_count == 8'h00 && timer4_count == 8'h00)
        else $error("count not cleared by reset");
endmodule : dual_timer_ctrl_checker
bind dual_timer_ctrl dual_timer_ctrl_checker i_chk (.*);
`default_nettype wire

// file: dv/dual_timer_ctrl_tb.sv
// self-checking bench for the dual timer control block
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_params.svh"
module dual_timer_ctrl_tb
    import dual_timer_pkg::*;
;
    // design inputs and outputs
    logic        ref_clk = 1'b0, srst = 1'b1, low_freq_clock = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, timer3_pin = 1'b0, timer4_pin = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, timer3_flipflop, timer4_flipflop;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0]  timer3_count, timer4_count;
    // bench state and model of offsets 18h to 1Dh
    int          n_fail = 0, n_compared = 0, seed = 51, n;
    logic [7:0]  mdl [0:5] = '{default: 8'h00};
    ctrl_s       c;

    dual_timer_ctrl i_dut (.*);

    // system clock and a slow low-frequency clock
    always #4 ref_clk = ~ref_clk;
    always begin
        repeat (12) @(posedge ref_clk);
        low_freq_clock <= ~low_freq_clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    function automatic logic mapped(input logic [7:0] off);
        return off inside {[8'h18:8'h1D], [8'h20:8'h22]};
    endfunction : mapped

    // one write; ready for the response comes after a random delay
    task automatic bus_wr(input logic [7:0] off, input logic [7:0] d,
                          input logic [3:0] stb);
        int k, dly;
        logic [2:0] got;
        logic [1:0] rsp;
        k = 0;
        got = 3'b000;
        dly = {$random(seed)} % 4;
        s_axi_awaddr <= 8'(`IDX_TO_ADDR(off));
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_wstrb <= stb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (got != 3'b111) begin
            @(posedge ref_clk);
            if (k++ == dly) s_axi_bready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready) begin
                got[0] = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                got[1] = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                got[2] = 1'b1;
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        check(32'(rsp), mapped(off) ? 32'h0 : 32'h2);
        if (mapped(off) && stb[0] && off < 8'h1E) mdl[off - 8'h18] = d;
    endtask : bus_wr

    // one read compared with the model
    task automatic bus_rd(input logic [7:0] off);
        int k, dly;
        logic [31:0] exp, rx;
        k = 0;
        exp = mapped(off) ? {24'h0, mdl[off - 8'h18]} : 32'h0;
        rx = mapped(off) ? 32'h0 : 32'h2;
        dly = {$random(seed)} % 4;
        s_axi_araddr <= 8'(`IDX_TO_ADDR(off));
        s_axi_arvalid <= 1'b1;
        while (k >= 0) begin
            @(posedge ref_clk);
            if (k++ == dly) s_axi_rready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                k = -1;
                s_axi_rready <= 1'b0;
                check(32'(s_axi_rresp), rx);
                check(s_axi_rdata, exp);
            end
        end
    endtask : bus_rd

    task automatic ctl(input int ch);
        bus_wr(8'h18 + 8'(ch), c, 4'h1);
    endtask : ctl

    // waits a bounded time for a channel count to leave zero
    task automatic poll(input int ch, input int lim);
        n = 0;
        while ((ch ? timer4_count : timer3_count) === 8'h00 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(n < lim), 32'h1);
    endtask : poll

    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++) bus_rd(8'h18 + 8'(i));
        for (int i = 0; i < 12; i++) begin
            c = ctrl_s'(8'($random(seed)));
            c.run = 1'b0;
            bus_wr(8'h18 + 8'(i % 6), c, {3'($random(seed)), 1'b1});
            bus_rd(8'h18 + 8'(i % 6));
        end
        bus_wr(8'h1A, 8'h5C, 4'hE);
        bus_rd(8'h1A);
        bus_wr(8'h30, 8'h77, 4'hF);
        bus_rd(8'h30);
        bus_wr(8'h1A, 8'hFF, 4'h1);
        bus_wr(8'h1C, 8'hFF, 4'h1);
        bus_wr(8'h19, 8'h00, 4'h1);
        // pin counting, flip-flop preset and stop-clear on both channels
        for (int ch = 0; ch < 2; ch++) begin
            c = '{ch == 0, CLK_PIN, 1'b0, MODE_TIMER8};
            ctl(ch);
            repeat (2) @(posedge ref_clk);
            check(ch ? timer4_flipflop : timer3_flipflop, ch == 0);
            c.run = 1'b1;
            ctl(ch);
            n = 3 + {$random(seed)} % 8;
            repeat (n) begin
                {timer4_pin, timer3_pin} <= 2'(1 << ch);
                repeat (4) @(posedge ref_clk);
                {timer4_pin, timer3_pin} <= 2'b00;
                repeat (4) @(posedge ref_clk);
            end
            repeat (8) @(posedge ref_clk);
            check(ch ? timer4_count : timer3_count, n);
            c.run = 1'b0;
            ctl(ch);
            repeat (2) @(posedge ref_clk);
            check(ch ? timer4_count : timer3_count, 32'h0);
        end
        // every internal clock source makes the counter advance
        for (int k = 0; k < 7; k++) begin
            c = '{1'b0, clk_sel_e'(k), 1'b1, MODE_TIMER8};
            ctl(0);
            poll(0, 5000);
            c.run = 1'b0;
            ctl(0);
        end
        // low-frequency option moves the slowest source to low clock / 8
        bus_wr(8'h20, 8'h01, 4'h1);
        c = '{1'b0, CLK_DIV11, 1'b1, MODE_TIMER8};
        ctl(0);
        poll(0, 1000);
        c.run = 1'b0;
        ctl(0);
        bus_wr(8'h20, 8'h00, 4'h1);
        // cascade: second channel runs and counts first overflow
        c = '{1'b0, CLK_FULL, 1'b0, MODE_CASCADE};
        ctl(0);
        c = '{1'b1, CLK_PIN, 1'b1, MODE_TIMER16};
        ctl(1);
        poll(1, 2000);
        c.run = 1'b0;
        ctl(1);
        repeat (2) @(posedge ref_clk);
        check({timer4_count, timer3_count}, 32'h0);
        bus_wr(8'h19, 8'h00, 4'h1);
        c = '{1'b0, CLK_PIN, 1'b1, MODE_PWM8};
        ctl(0);
        bus_wr(8'h1B, 8'h3C, 4'h1);
        bus_rd(8'h1B);
        complete_run();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end
endmodule : dual_timer_ctrl_tb
`default_nettype wire

// file: logic/dual_timer_ctrl.sv
// dual 8-bit timer control with AXI4-Lite register access
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_params.svh"

module dual_timer_ctrl
    import dual_timer_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // external count pins and low-frequency clock, asynchronous
    input  wire logic        timer3_pin,
    input  wire logic        timer4_pin,
    input  wire logic        low_freq_clock,
    // timer state outputs
    output logic             timer3_flipflop,
    output logic             timer4_flipflop,
    output logic [7:0]       timer3_count,
    output logic [7:0]       timer4_count
);

    typedef struct packed {
        ctrl_s       t3;
        ctrl_s       t4;
        logic [7:0]  per3;
        logic [7:0]  pw3;
        logic [7:0]  per4;
        logic [7:0]  pw4;
        logic        low_opt;
        logic        low_speed;
        logic [7:0]  cnt3;
        logic [7:0]  cnt4;
        logic        ff3;
        logic        ff4;
        logic [`DIV_W-1:0]    div;
        logic [`LOWDIV_W-1:0] ldiv;
        logic [2:0]  sync3;
        logic [2:0]  sync4;
        logic [2:0]  synlo;
        logic        pin3_lvl;
        logic        pin4_lvl;
        logic        lo_lvl;
        logic        aw_hold;
        logic [7:0]  aw_addr;
        logic        w_hold;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        bus_state_e  bst;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_s;

    state_s st_reg;
    state_s st_next;

    // register index of a word-aligned byte address
    // the two low address bits are not decoded
    function automatic logic [7:0] reg_idx(input logic [7:0] a);
        reg_idx = {2'b00, a[7:2]};
    endfunction : reg_idx

    // true when an address maps to a register
    function automatic logic addr_ok(input logic [7:0] a);
        case (reg_idx(a))
            `OFS_T3_CTRL, `OFS_T4_CTRL, `OFS_T3_PERIOD, `OFS_T3_PWIDTH,
            `OFS_T4_PERIOD, `OFS_T4_PWIDTH, `OFS_OPTIONS, `OFS_STATUS,
            `OFS_COUNT: addr_ok = 1'b1;
            default:    addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // tick of the selected source: divider chain taps, low clock, full rate or pin edge
    function automatic logic src_tick(input clk_sel_e sel,
                                      input logic [`DIV_W-1:0] d,
                                      input logic [`LOWDIV_W-1:0] ld,
                                      input logic lo_opt,
                                      input logic lo_edge,
                                      input logic pin_edge);
        case (sel)
            CLK_DIV11: src_tick = lo_opt ? (lo_edge && ld == '1)
                                         : (d == '1);
            CLK_DIV7:  src_tick = (d[6:0] == '1);
            CLK_DIV5:  src_tick = (d[4:0] == '1);
            CLK_DIV3:  src_tick = (d[2:0] == '1);
            CLK_LOW:   src_tick = lo_edge;
            CLK_DIV1:  src_tick = d[0];
            CLK_FULL:  src_tick = 1'b1;
            CLK_PIN:   src_tick = pin_edge;
            default:   src_tick = 1'b0;
        endcase
    endfunction : src_tick

    // one control byte from a control struct
    function automatic logic [7:0] ctrl_byte(input ctrl_s c);
        ctrl_byte = c;
    endfunction : ctrl_byte

    logic cascade;
    logic run3;
    logic run4;
    logic lo_edge;
    logic pin3_rise;
    logic pin4_rise;
    logic tick3;
    logic tick4;
    logic ovf3;
    logic [7:0] wb;
    logic do_wr;
    logic [7:0] rsel;

    // next-state logic for registers, counters and bus
    always_comb begin
        st_next = st_reg;
        // three-stage synchronisers, second and third stages compared
        st_next.sync3 = {st_reg.sync3[1:0], timer3_pin};
        st_next.sync4 = {st_reg.sync4[1:0], timer4_pin};
        st_next.synlo = {st_reg.synlo[1:0], low_freq_clock};
        st_next.div   = st_reg.div + 1'b1;
        // a rise to high counts once the second and third stages agree
        pin3_rise = st_reg.sync3[2] && st_reg.sync3[1] && !st_reg.pin3_lvl;
        pin4_rise = st_reg.sync4[2] && st_reg.sync4[1] && !st_reg.pin4_lvl;
        lo_edge   = st_reg.synlo[2] && st_reg.synlo[1]
                    && !st_reg.lo_lvl;
        if (st_reg.sync3[2] == st_reg.sync3[1]) begin
            st_next.pin3_lvl = st_reg.sync3[2];
        end
        if (st_reg.sync4[2] == st_reg.sync4[1]) begin
            st_next.pin4_lvl = st_reg.sync4[2];
        end
        if (st_reg.synlo[2] == st_reg.synlo[1]) begin
            st_next.lo_lvl = st_reg.synlo[2];
        end
        if (lo_edge) begin
            st_next.ldiv = st_reg.ldiv + 1'b1;
        end
        // cascade is chosen by the second channel's top mode bit
        cascade = st_reg.t4.mode[2];
        run3 = cascade ? st_reg.t4.run : st_reg.t3.run;
        run4 = st_reg.t4.run;
        tick3 = src_tick(st_reg.t3.clk, st_reg.div, st_reg.ldiv,
                         st_reg.low_opt | st_reg.low_speed, lo_edge,
                         pin3_rise);
        // lower counter wraps at its period, or 0xFF when cascaded
        ovf3 = tick3 && (cascade ? (st_reg.cnt3 == 8'hFF)
                                 : (st_reg.cnt3 == st_reg.per3));
        tick4 = cascade ? ovf3
              : src_tick(st_reg.t4.clk, st_reg.div, st_reg.ldiv,
                         st_reg.low_opt | st_reg.low_speed, lo_edge,
                         pin4_rise);
        // first channel counter
        if (!run3) begin
            st_next.cnt3 = 8'h00;
            st_next.ff3  = cascade ? st_reg.t4.ff_init
                                   : st_reg.t3.ff_init;
        end else if (tick3) begin
            st_next.cnt3 = ovf3 ? 8'h00 : st_reg.cnt3 + 1'b1;
            if (ovf3 && st_reg.t3.mode != MODE_TIMER8) begin
                st_next.ff3 = !st_reg.ff3;
            end
        end
        // second channel counter
        if (!run4) begin
            st_next.cnt4 = 8'h00;
            st_next.ff4  = st_reg.t4.ff_init;
        end else if (tick4) begin
            if (!cascade && st_reg.cnt4 == st_reg.per4) begin
                st_next.cnt4 = 8'h00;
                if (st_reg.t4.mode != MODE_TIMER8) begin
                    st_next.ff4 = !st_reg.ff4;
                end
            end else begin
                st_next.cnt4 = st_reg.cnt4 + 1'b1;
            end
        end
        // axi write: take address and data in either order
        st_next.awready = 1'b0;
        st_next.wready  = 1'b0;
        st_next.arready = 1'b0;
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_hold = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_hold = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        do_wr = 1'b0;
        wb    = st_reg.w_data[7:0];
        rsel  = 8'h00;
        // bus state: idle, write answer pending, read answer pending
        case (st_reg.bst)
            BUS_IDLE: begin
                st_next.awready = !st_reg.aw_hold && !st_next.aw_hold;
                st_next.wready  = !st_reg.w_hold && !st_next.w_hold;
                if (st_reg.aw_hold && st_reg.w_hold) begin
                    do_wr = st_reg.w_strb[0];
                    st_next.aw_hold = 1'b0;
                    st_next.w_hold  = 1'b0;
                    st_next.bvalid  = 1'b1;
                    st_next.bresp   = addr_ok(st_reg.aw_addr) ? 2'h0 : 2'h2;
                    st_next.awready = 1'b0;
                    st_next.wready  = 1'b0;
                    st_next.bst     = BUS_WRESP;
                end else if (s_axi_arvalid && st_reg.arready) begin
                    case (reg_idx(s_axi_araddr))
                        `OFS_T3_CTRL:   rsel = ctrl_byte(st_reg.t3);
                        `OFS_T4_CTRL:   rsel = ctrl_byte(st_reg.t4);
                        `OFS_T3_PERIOD: rsel = st_reg.per3;
                        `OFS_T3_PWIDTH: rsel = st_reg.pw3;
                        `OFS_T4_PERIOD: rsel = st_reg.per4;
                        `OFS_T4_PWIDTH: rsel = st_reg.pw4;
                        `OFS_OPTIONS:   rsel = {6'h00, st_reg.low_speed,
                                                st_reg.low_opt};
                        `OFS_STATUS:    rsel = {4'h0, cascade, run4,
                                                st_reg.ff4, st_reg.ff3};
                        `OFS_COUNT:     rsel = st_reg.cnt3;
                        default:        rsel = 8'h00;
                    endcase
                    st_next.rdata  = {24'h000000, rsel};
                    st_next.rresp  = addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
                    st_next.rvalid = 1'b1;
                    st_next.bst    = BUS_RRESP;
                end else begin
                    // no read offer while a complete write is about to run
                    st_next.arready = !st_reg.arready
                                   && !(st_next.aw_hold && st_next.w_hold);
                end
            end
            BUS_WRESP: begin
                if (s_axi_bready) begin
                    st_next.bvalid = 1'b0;
                    st_next.bst    = BUS_IDLE;
                end
            end
            BUS_RRESP: begin
                if (s_axi_rready) begin
                    st_next.rvalid = 1'b0;
                    st_next.bst    = BUS_IDLE;
                end
            end
            default: st_next.bst = BUS_IDLE;
        endcase
        // writes while counting are not blocked; software keeps fields fixed
        // register writes, low byte lane only
        if (do_wr) begin
            case (reg_idx(st_reg.aw_addr))
                `OFS_T3_CTRL:   st_next.t3 = ctrl_s'(wb);
                `OFS_T4_CTRL:   st_next.t4 = ctrl_s'(wb);
                `OFS_T3_PERIOD: st_next.per3 = wb;
                `OFS_T3_PWIDTH: st_next.pw3 = wb;
                `OFS_T4_PERIOD: st_next.per4 = wb;
                `OFS_T4_PWIDTH: st_next.pw4 = wb;
                `OFS_OPTIONS: begin
                    st_next.low_opt   = wb[0];
                    st_next.low_speed = wb[1];
                end
                default: st_next.low_opt = st_reg.low_opt;
            endcase
        end
    end

    // state register with synchronous reset
    // filtered pin levels start low, so no false edge follows reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg         <= '0;
            st_reg.t3      <= ctrl_s'(`RST_CTRL);
            st_reg.t4      <= ctrl_s'(`RST_CTRL);
            st_reg.per3    <= `RST_TREG;
            st_reg.pw3     <= `RST_TREG;
            st_reg.per4    <= `RST_TREG;
            st_reg.pw4     <= `RST_TREG;
            st_reg.bst     <= BUS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready   = st_reg.awready;
    assign s_axi_wready    = st_reg.wready;
    assign s_axi_bvalid    = st_reg.bvalid;
    assign s_axi_bresp     = st_reg.bresp;
    assign s_axi_arready   = st_reg.arready;
    assign s_axi_rvalid    = st_reg.rvalid;
    assign s_axi_rdata     = st_reg.rdata;
    assign s_axi_rresp     = st_reg.rresp;
    assign timer3_flipflop = st_reg.ff3;
    assign timer4_flipflop = st_reg.ff4;
    assign timer3_count    = st_reg.cnt3;
    assign timer4_count    = st_reg.cnt4;

endmodule : dual_timer_ctrl
`default_nettype wire

// file: logic/dual_timer_params.svh
// register offsets, field positions, reset values and divider widths
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
`define OFS_T3_CTRL      8'h18
`define OFS_T4_CTRL      8'h19
`define OFS_T3_PERIOD    8'h1A
`define OFS_T3_PWIDTH    8'h1B
`define OFS_T4_PERIOD    8'h1C
`define OFS_T4_PWIDTH    8'h1D
`define OFS_OPTIONS      8'h20
`define OFS_STATUS       8'h21
`define OFS_COUNT        8'h22
`define IDX_TO_ADDR(i)   {(i), 2'b00}
`define FLD_MODE_LSB     0
`define FLD_RUN_BIT      3
`define FLD_CLK_LSB      4
`define FLD_FF_BIT       7
`define RST_CTRL         8'h00
`define RST_TREG         8'h00
`define DIV_W            11
`define LOWDIV_W         3
`endif

// file: logic/dual_timer_pkg.sv
// types shared by the dual 8-bit timer control block
package dual_timer_pkg;
    typedef enum logic [2:0] {
        CLK_DIV11, CLK_DIV7, CLK_DIV5, CLK_DIV3,
        CLK_LOW, CLK_DIV1, CLK_FULL, CLK_PIN
    } clk_sel_e;
    typedef enum logic [2:0] {
        MODE_TIMER8, MODE_DIVOUT8, MODE_PWM8, MODE_CASCADE,
        MODE_TIMER16, MODE_WARMUP16, MODE_PWM16, MODE_PULSE16
    } mode_e;
    typedef struct packed {
        logic     ff_init;
        clk_sel_e clk;
        logic     run;
        mode_e    mode;
    } ctrl_s;
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_WRESP, BUS_RRESP
    } bus_state_e;
endpackage : dual_timer_pkg
